// >>> rtl/drive_status_velocity_limits.sv
/*
 * Drive status word and velocity-mode parameter entries.
 * Assumes the power state, fault, warning, sync and mode information
 * come from logic on the same clock; dictionary accesses arrive as a
 * single-cycle strobe with index and subindex.
 */
//
// Behaviour
// - Bits 0-2 flag ready, switched on, enabled
// - Bit 5 low in halt, 6 high in inhibit
// - Bit 8 shows fieldbus synchronisation
// - Bit 9 one unless special modes
// - Bit 15 when enabled with closed loop
// - Not ready and inhibit nibble encodings
// - Ready, switched on, enabled nibble encodings
// - Halt, fault reaction, fault encodings
// - Bits 12, 13 come from mode logic
// - Signed target speed, rw, reset 00C8
// - Signed actual speed, read only, reset zero
// - Min and max limits, reset 0 / 7530
// - Below minimum uses minimum, sets bit 11
// - Above maximum uses maximum, sets bit 11
// - Ramp rate is speed step per time step
`timescale 1ns/1ps

module drive_status_velocity_limits
    import drive_status_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Dictionary access port
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [15:0] i_acc_index,
    input wire logic [7:0] i_acc_subindex,
    input wire logic [31:0] i_acc_wdata,
    output logic [31:0] o_acc_rdata,
    output logic o_acc_ack,
    output logic o_acc_error,
    // Drive state inputs from the power state machine
    input wire power_state_t i_power_state,
    input wire logic i_fault,
    input wire logic i_voltage_present,
    input wire logic i_warning,
    input wire logic i_bus_synced,
    input wire logic i_special_mode,
    input wire logic i_closed_loop,
    input wire logic [1:0] i_mode_specific_bits,
    input wire logic signed [15:0] i_speed_actual,
    // Outputs toward the speed loop
    output logic [15:0] o_drive_state_word,
    output logic signed [15:0] o_speed_demand
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Magnitude of a signed 16-bit speed, widened to 32 bits
    function automatic logic [31:0] speed_mag(input logic signed [15:0] v);
        logic [16:0] wide;
        wide = {v[15], v};
        if (v[15]) begin
            wide = 17'(-$signed(wide));
        end
        return {15'h0000, wide};
    endfunction

    // Apply the sign of a reference onto a magnitude, saturating to 16 bits
    function automatic logic [15:0] signed_from_mag(input logic [31:0] mag, input logic neg);
        logic [15:0] m;
        m = (mag > 32'h0000_7FFF) ? 16'h7FFF : mag[15:0];
        return neg ? 16'(-m) : m;
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] target_speed_ff; // Commanded speed, signed
    logic [15:0] speed_actual_ff; // Captured actual speed
    logic [31:0] speed_lower_limit_ff; // Minimum magnitude
    logic [31:0] speed_upper_limit_ff; // Maximum magnitude
    logic [31:0] accel_speed_step_ff; // Ramp speed delta
    logic [15:0] accel_time_step_ff; // Ramp time delta in cycles
    logic [15:0] time_count_ff; // Cycles since the last ramp step
    logic [15:0] speed_demand_ff; // Ramped demand
    logic limit_active_flag_ff; // Clamp in effect
    logic [15:0] state_word_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic err_ff;

    logic [31:0] tgt_mag;
    logic [15:0] clamped_target;
    logic nxt_limit;
    logic [15:0] nxt_state_word;
    logic wr;

    assign wr = i_acc_valid && i_acc_write;
    assign tgt_mag = speed_mag(target_speed_ff);

    // ------------------------------------------------------------
    // Target clamping
    // ------------------------------------------------------------
    // Limits act on the magnitude so reverse speeds clamp symmetrically
    always_comb begin
        clamped_target = target_speed_ff;
        nxt_limit = 1'b0; // Inside limits clears the flag
        if (tgt_mag < speed_lower_limit_ff) begin
            clamped_target = signed_from_mag(speed_lower_limit_ff, target_speed_ff[15]);
            nxt_limit = 1'b1;
        end else if (tgt_mag > speed_upper_limit_ff) begin
            clamped_target = signed_from_mag(speed_upper_limit_ff, target_speed_ff[15]);
            nxt_limit = 1'b1;
        end
    end

    // Limit flag follows the present clamp decision
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            limit_active_flag_ff <= 1'b0;
        end else begin
            limit_active_flag_ff <= nxt_limit;
        end
    end

    // ------------------------------------------------------------
    // Acceleration ramp
    // ------------------------------------------------------------
    // Every accel_time_step cycles the demand moves by at most
    // accel_speed_step toward the clamped target; a zero time step is
    // treated as one so the ramp never stalls.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            time_count_ff <= RST_TIME_COUNT;
            speed_demand_ff <= RST_SPEED_DEMAND;
        end else if (time_count_ff + 16'h0001 >= accel_time_step_ff) begin
            time_count_ff <= RST_TIME_COUNT;
            // Step toward target, never overshooting
            if ($signed(speed_demand_ff) < $signed(clamped_target)) begin
                if (32'($signed(clamped_target) - $signed(speed_demand_ff)) <= accel_speed_step_ff) begin
                    speed_demand_ff <= clamped_target;
                end else begin
                    speed_demand_ff <= speed_demand_ff + accel_speed_step_ff[15:0];
                end
            end else if ($signed(speed_demand_ff) > $signed(clamped_target)) begin
                if (32'($signed(speed_demand_ff) - $signed(clamped_target)) <= accel_speed_step_ff) begin
                    speed_demand_ff <= clamped_target;
                end else begin
                    speed_demand_ff <= speed_demand_ff - accel_speed_step_ff[15:0];
                end
            end
        end else begin
            time_count_ff <= time_count_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // Low nibble, bits 5 and 6 come from the power state encoding
    always_comb begin
        nxt_state_word = RST_STATE_WORD;
        case (i_power_state)
            PS_NOT_READY: nxt_state_word[6:0] = 7'b000_0000;
            PS_SW_INHIBIT: nxt_state_word[6:0] = 7'b100_0000;
            PS_READY: nxt_state_word[6:0] = 7'b010_0001;
            PS_SWITCHED_ON: nxt_state_word[6:0] = 7'b010_0011;
            PS_OP_ENABLED: nxt_state_word[6:0] = 7'b010_0111;
            PS_HALT_ACTIVE: nxt_state_word[6:0] = 7'b000_0111;
            PS_FAULT_REACT: nxt_state_word[6:0] = 7'b000_1111;
            PS_FAULT: nxt_state_word[6:0] = 7'b000_1000;
            default: nxt_state_word[6:0] = 7'b000_0000;
        endcase
        // Error bit also follows an external fault outside fault states
        nxt_state_word[BIT_FAULT] = nxt_state_word[BIT_FAULT] | i_fault;
        nxt_state_word[BIT_VOLTAGE] = i_voltage_present;
        nxt_state_word[BIT_WARNING] = i_warning;
        nxt_state_word[BIT_SYNC] = i_bus_synced;
        nxt_state_word[BIT_HOST_CTRL] = !i_special_mode;
        nxt_state_word[BIT_GOAL] = (speed_demand_ff == clamped_target);
        nxt_state_word[BIT_LIMIT] = limit_active_flag_ff;
        nxt_state_word[BIT_MODE_HI:BIT_MODE_LO] = i_mode_specific_bits;
        nxt_state_word[BIT_CLOSED_LOOP] = (i_power_state == PS_OP_ENABLED) && i_closed_loop;
    end

    // Registered status word
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_word_ff <= RST_STATE_WORD;
        end else begin
            state_word_ff <= nxt_state_word;
        end
    end

    // Actual speed capture; the source is on this clock
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            speed_actual_ff <= RST_SPEED_ACTUAL;
        end else begin
            speed_actual_ff <= i_speed_actual;
        end
    end

    // ------------------------------------------------------------
    // Dictionary writes
    // ------------------------------------------------------------
    // Only the writable entries accept data; others are refused
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            target_speed_ff <= RST_TARGET_SPEED;
            speed_lower_limit_ff <= RST_SPEED_LOWER;
            speed_upper_limit_ff <= RST_SPEED_UPPER;
            accel_speed_step_ff <= RST_ACCEL_SPEED;
            accel_time_step_ff <= RST_ACCEL_TIME;
        end else if (wr) begin
            if (i_acc_index == IDX_TARGET_SPEED && i_acc_subindex == SUB_COUNT) begin
                target_speed_ff <= i_acc_wdata[15:0];
            end
            if (i_acc_index == IDX_SPEED_LIMITS && i_acc_subindex == SUB_FIRST) begin
                speed_lower_limit_ff <= i_acc_wdata;
            end
            if (i_acc_index == IDX_SPEED_LIMITS && i_acc_subindex == SUB_SECOND) begin
                speed_upper_limit_ff <= i_acc_wdata;
            end
            if (i_acc_index == IDX_ACCEL && i_acc_subindex == SUB_FIRST) begin
                accel_speed_step_ff <= i_acc_wdata;
            end
            if (i_acc_index == IDX_ACCEL && i_acc_subindex == SUB_SECOND) begin
                accel_time_step_ff <= i_acc_wdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Dictionary reads and answers
    // ------------------------------------------------------------
    // One-cycle answer; error for unknown entries and read-only writes
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            ack_ff <= i_acc_valid;
            err_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            if (i_acc_valid) begin
                case (i_acc_index)
                    IDX_DRIVE_STATE_WORD: begin
                        rdata_ff <= {16'h0000, state_word_ff};
                        err_ff <= i_acc_write || (i_acc_subindex != SUB_COUNT);
                    end
                    IDX_TARGET_SPEED: begin
                        rdata_ff <= {{16{target_speed_ff[15]}}, target_speed_ff};
                        err_ff <= (i_acc_subindex != SUB_COUNT);
                    end
                    IDX_SPEED_DEMAND: begin
                        rdata_ff <= {{16{speed_demand_ff[15]}}, speed_demand_ff};
                        err_ff <= i_acc_write || (i_acc_subindex != SUB_COUNT);
                    end
                    IDX_SPEED_ACTUAL: begin
                        rdata_ff <= {{16{speed_actual_ff[15]}}, speed_actual_ff};
                        err_ff <= i_acc_write || (i_acc_subindex != SUB_COUNT);
                    end
                    IDX_SPEED_LIMITS, IDX_ACCEL: begin
                        case (i_acc_subindex)
                            SUB_COUNT: begin
                                rdata_ff <= RECORD_ENTRIES;
                                err_ff <= i_acc_write;
                            end
                            SUB_FIRST: begin
                                rdata_ff <= (i_acc_index == IDX_ACCEL) ? accel_speed_step_ff : speed_lower_limit_ff;
                            end
                            SUB_SECOND: begin
                                rdata_ff <= (i_acc_index == IDX_ACCEL) ? {16'h0000, accel_time_step_ff}
                                                                       : speed_upper_limit_ff;
                            end
                            default: begin
                                err_ff <= 1'b1;
                            end
                        endcase
                    end
                    default: begin
                        err_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_acc_rdata = rdata_ff;
    assign o_acc_ack = ack_ff;
    assign o_acc_error = err_ff;
    assign o_drive_state_word = state_word_ff;
    assign o_speed_demand = speed_demand_ff;

endmodule

// >>> rtl/drive_status_pkg.sv
/*
 * Package for the drive status and velocity parameter block:
 * dictionary indices, subindices, status bit positions, reset values,
 * power-state enumeration.
 * Assumes one system clock; the dictionary port is a simple
 * index/subindex read-write port driven by the fieldbus stack.
 */
package drive_status_pkg;

    // ------------------------------------------------------------
    // Dictionary indices and subindices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_DRIVE_STATE_WORD = 16'h6041;
    localparam logic [15:0] IDX_TARGET_SPEED = 16'h6042;
    localparam logic [15:0] IDX_SPEED_DEMAND = 16'h6043;
    localparam logic [15:0] IDX_SPEED_ACTUAL = 16'h6044;
    localparam logic [15:0] IDX_SPEED_LIMITS = 16'h6046;
    localparam logic [15:0] IDX_ACCEL = 16'h6048;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST = 8'h01;
    localparam logic [7:0] SUB_SECOND = 8'h02;
    localparam logic [31:0] RECORD_ENTRIES = 32'h0000_0002;

    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int BIT_READY = 0;
    localparam int BIT_SWITCHED_ON = 1;
    localparam int BIT_OP_ENABLED = 2;
    localparam int BIT_FAULT = 3;
    localparam int BIT_VOLTAGE = 4;
    localparam int BIT_HALT_N = 5;
    localparam int BIT_SW_INHIBIT = 6;
    localparam int BIT_WARNING = 7;
    localparam int BIT_SYNC = 8;
    localparam int BIT_HOST_CTRL = 9;
    localparam int BIT_GOAL = 10;
    localparam int BIT_LIMIT = 11;
    localparam int BIT_MODE_LO = 12;
    localparam int BIT_MODE_HI = 13;
    localparam int BIT_CLOSED_LOOP = 15;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_STATE_WORD = 16'h0000;
    localparam logic [15:0] RST_TARGET_SPEED = 16'h00C8;
    localparam logic [15:0] RST_SPEED_DEMAND = 16'h0000;
    localparam logic [15:0] RST_SPEED_ACTUAL = 16'h0000;
    localparam logic [31:0] RST_SPEED_LOWER = 32'h0000_0000;
    localparam logic [31:0] RST_SPEED_UPPER = 32'h0000_7530;
    localparam logic [31:0] RST_ACCEL_SPEED = 32'h0000_01F4;
    localparam logic [15:0] RST_ACCEL_TIME = 16'h0001;
    localparam logic [15:0] RST_TIME_COUNT = 16'h0000;

    // ------------------------------------------------------------
    // Power states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        PS_NOT_READY = 8'b0000_0001,
        PS_SW_INHIBIT = 8'b0000_0010,
        PS_READY = 8'b0000_0100,
        PS_SWITCHED_ON = 8'b0000_1000,
        PS_OP_ENABLED = 8'b0001_0000,
        PS_HALT_ACTIVE = 8'b0010_0000,
        PS_FAULT_REACT = 8'b0100_0000,
        PS_FAULT = 8'b1000_0000
    } power_state_t;

endpackage

// >>> bench/fieldbus_master_model.sv
/*
 * Fieldbus master model: issues dictionary reads and writes.
 * Assumes the one-cycle strobe and next-edge acknowledge of the block.
 */
`timescale 1ns/1ps

module fieldbus_master_model (
    // Clock
    input wire logic i_clk,
    // Request side
    output logic o_acc_valid,
    output logic o_acc_write,
    output logic [15:0] o_acc_index,
    output logic [7:0] o_acc_subindex,
    output logic [31:0] o_acc_wdata,
    // Answer side
    input wire logic [31:0] i_acc_rdata,
    input wire logic i_acc_ack,
    input wire logic i_acc_error
);
    // --------------------------------------------------------
    // One access: strobe for one cycle, wait for the ack
    // --------------------------------------------------------
    initial begin
        o_acc_valid = 1'b0;
        o_acc_write = 1'b0;
        o_acc_index = 16'h0000;
        o_acc_subindex = 8'h00;
        o_acc_wdata = 32'h0000_0000;
    end

    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        o_acc_valid = 1'b1;
        o_acc_write = wr; // Writes command new values
        o_acc_index = idx;
        o_acc_subindex = sub;
        o_acc_wdata = wd;
        @(posedge i_clk);
        #1;
        // Released lines show inverted garbage, never the old value
        o_acc_valid = 1'b0;
        o_acc_write = ~wr;
        o_acc_index = ~idx;
        o_acc_subindex = ~sub;
        o_acc_wdata = ~wd;
        while (i_acc_ack !== 1'b1 && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        rd = (n < 4) ? i_acc_rdata : 32'hxxxx_xxxx;
        er = (n < 4) ? i_acc_error : 1'bx;
    endtask
endmodule

// >>> bench/drive_status_velocity_limits_monitor.sv
/*
 * Checker for the status word encodings and the access handshake.
 * Assumes the word is registered one cycle after its inputs.
 */
`timescale 1ns/1ps

module drive_status_velocity_limits_monitor
    import drive_status_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [15:0] i_acc_index,
    input wire logic o_acc_ack,
    input wire logic o_acc_error,
    input wire power_state_t i_power_state,
    input wire logic i_fault,
    input wire logic i_voltage_present,
    input wire logic i_warning,
    input wire logic i_bus_synced,
    input wire logic i_special_mode,
    input wire logic i_closed_loop,
    input wire logic [1:0] i_mode_specific_bits,
    input wire logic [15:0] o_drive_state_word
);
    // --------------------------------------------------------
    // Clocking and sequences
    // --------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_in(power_state_t ps);
        i_power_state == ps && !i_fault;
    endsequence
    sequence s_ro_write;
        i_acc_valid && i_acc_write && (i_acc_index == IDX_SPEED_ACTUAL || i_acc_index == IDX_DRIVE_STATE_WORD);
    endsequence
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    property p_ack; i_acc_valid |=> o_acc_ack; endproperty
    property p_ro; s_ro_write |=> o_acc_ack && o_acc_error; endproperty
    property p_inhibit; s_in(PS_SW_INHIBIT) |=> o_drive_state_word[6] && o_drive_state_word[3:0] == 4'h0; endproperty
    property p_enabled; s_in(PS_OP_ENABLED) |=> o_drive_state_word[6:5] == 2'b01 && o_drive_state_word[3:0] == 4'h7;
    endproperty
    property p_halt; s_in(PS_HALT_ACTIVE) |=> o_drive_state_word[6:5] == 2'b00 && o_drive_state_word[3:0] == 4'h7;
    endproperty
    property p_fault; s_in(PS_FAULT) |=> !o_drive_state_word[6] && o_drive_state_word[3:0] == 4'h8; endproperty
    property p_flags; i_rstn |=> o_drive_state_word[8] == $past(i_bus_synced) &&
        o_drive_state_word[9] == !$past(i_special_mode) && o_drive_state_word[13:12] == $past(i_mode_specific_bits);
    endproperty
    property p_closed; i_rstn |=> o_drive_state_word[15] == $past(i_closed_loop && i_power_state == PS_OP_ENABLED);
    endproperty
    property p_misc; i_rstn |=> o_drive_state_word[4] == $past(i_voltage_present) &&
        o_drive_state_word[7] == $past(i_warning); endproperty
    a_ack: assert property (p_ack) else $error("no ack after access");
    a_ro: assert property (p_ro) else $error("read-only write not refused");
    a_inhibit: assert property (p_inhibit) else $error("inhibit encoding wrong");
    a_enabled: assert property (p_enabled) else $error("enabled encoding wrong");
    a_halt: assert property (p_halt) else $error("halt encoding wrong");
    a_fault: assert property (p_fault) else $error("fault encoding wrong");
    a_flags: assert property (p_flags) else $error("sync, host or mode bits wrong");
    a_closed: assert property (p_closed) else $error("closed loop bit wrong");
    a_misc: assert property (p_misc) else $error("voltage or warning bit wrong");
endmodule

bind drive_status_velocity_limits drive_status_velocity_limits_monitor i_mon (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_acc_valid(i_acc_valid), .i_acc_write(i_acc_write), .i_acc_index(i_acc_index), .o_acc_ack(o_acc_ack),
    .o_acc_error(o_acc_error), .i_power_state(i_power_state), .i_fault(i_fault),
    .i_voltage_present(i_voltage_present), .i_warning(i_warning), .i_bus_synced(i_bus_synced),
    .i_special_mode(i_special_mode), .i_closed_loop(i_closed_loop),
    .i_mode_specific_bits(i_mode_specific_bits), .o_drive_state_word(o_drive_state_word));

// >>> bench/test_drive_status_velocity_limits.sv
/*
 * Testbench: register reset values, refusals, state encodings,
 * speed clamping and the acceleration ramp.
 * Assumes a 125 MHz clock and the fieldbus master model.
 */
`timescale 1ns/1ps

module test_drive_status_velocity_limits;
    import drive_status_pkg::*;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    logic i_clk, i_rstn, acc_valid, acc_write, acc_ack, acc_error, fault, volt, warn, sync, special, closed;
    logic [15:0] acc_index, word, actual;
    logic [7:0] acc_sub;
    logic [31:0] acc_wdata, acc_rdata, rd;
    logic [1:0] mode;
    logic signed [15:0] demand;
    logic er;
    power_state_t pstate;
    int err_count, check_count;
    power_state_t st_tab [8] = '{PS_NOT_READY, PS_SW_INHIBIT, PS_READY, PS_SWITCHED_ON, PS_OP_ENABLED,
                                  PS_HALT_ACTIVE, PS_FAULT_REACT, PS_FAULT};
    logic [6:0] msk_tab [8] = '{7'h4F, 7'h4F, 7'h6F, 7'h6F, 7'h6F, 7'h6F, 7'h4F, 7'h4F};
    logic [6:0] val_tab [8] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0F, 7'h08};

    drive_status_velocity_limits i_drive_status_velocity_limits (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_acc_valid(acc_valid), .i_acc_write(acc_write), .i_acc_index(acc_index), .i_acc_subindex(acc_sub),
        .i_acc_wdata(acc_wdata), .o_acc_rdata(acc_rdata), .o_acc_ack(acc_ack), .o_acc_error(acc_error),
        .i_power_state(pstate), .i_fault(fault), .i_voltage_present(volt), .i_warning(warn),
        .i_bus_synced(sync), .i_special_mode(special), .i_closed_loop(closed), .i_mode_specific_bits(mode),
        .i_speed_actual(actual), .o_drive_state_word(word), .o_speed_demand(demand));
    fieldbus_master_model i_fieldbus_master_model (.i_clk(i_clk), .o_acc_valid(acc_valid),
        .o_acc_write(acc_write), .o_acc_index(acc_index), .o_acc_subindex(acc_sub), .o_acc_wdata(acc_wdata),
        .i_acc_rdata(acc_rdata), .i_acc_ack(acc_ack), .i_acc_error(acc_error));

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
            err_count++;
        end
    endtask
    // Read and compare data, and expect no error
    task automatic rdc(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
        i_fieldbus_master_model.access(1'b0, idx, sub, 32'h0000_0000, rd, er);
        chk(rd, exp, "read data");
        chk({31'h0, er}, 32'h0000_0000, "read error flag");
    endtask
    // Write and compare the refusal flag
    task automatic wrc(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
        i_fieldbus_master_model.access(1'b1, idx, sub, d, rd, er);
        chk({31'h0, er}, {31'h0, e}, "write error flag");
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic test_done;
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // Clock, watchdog
    // --------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        // Whole run needs well under a thousand cycles
        #(5000 * 8);
        err_count++;
        test_done;
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        {err_count, check_count} = 0;
        {i_rstn, fault, volt, warn, sync, special, closed, mode} = '0;
        pstate = PS_NOT_READY;
        actual = 16'hFFFB;
        wait_clk(12);
        i_rstn = 1'b1;
        // Reset values and sign extension
        rdc(IDX_TARGET_SPEED, SUB_COUNT, 32'h0000_00C8);
        rdc(IDX_SPEED_ACTUAL, SUB_COUNT, 32'hFFFF_FFFB);
        rdc(IDX_SPEED_LIMITS, SUB_COUNT, RECORD_ENTRIES);
        rdc(IDX_SPEED_LIMITS, SUB_FIRST, 32'h0000_0000);
        rdc(IDX_SPEED_LIMITS, SUB_SECOND, 32'h0000_7530);
        rdc(IDX_ACCEL, SUB_FIRST, 32'h0000_01F4);
        rdc(IDX_ACCEL, SUB_SECOND, 32'h0000_0001);
        // Read-only places and unknown index are refused
        wrc(IDX_SPEED_ACTUAL, SUB_COUNT, 32'h0000_1234, 1'b1);
        wrc(IDX_DRIVE_STATE_WORD, SUB_COUNT, 32'h0000_1234, 1'b1);
        wrc(IDX_SPEED_LIMITS, SUB_COUNT, 32'h0000_0005, 1'b1);
        wrc(16'h6045, SUB_COUNT, 32'h0000_0005, 1'b1);
        // Every power state encoding, word read over the bus too
        for (int k = 0; k < 8; k++) begin
            pstate = st_tab[k];
            wait_clk(2);
            chk({25'h0, word[6:0] & msk_tab[k]}, {25'h0, val_tab[k]}, "state encoding");
            i_fieldbus_master_model.access(1'b0, IDX_DRIVE_STATE_WORD, SUB_COUNT, 32'h0, rd, er);
            chk({25'h0, rd[6:0] & msk_tab[k]}, {25'h0, val_tab[k]}, "state word read");
        end
        // Side flags
        {fault, volt, warn, sync, special, closed, mode} = 8'b1111_1111;
        pstate = PS_OP_ENABLED;
        wait_clk(2);
        chk({16'h0, word & 16'hB398}, 32'h0000_B198, "flags set");
        {fault, volt, warn, sync, special, closed, mode} = 8'b0001_0010;
        wait_clk(2);
        chk({16'h0, word & 16'hB398}, 32'h0000_2300, "flags clear");
        // Target below minimum, both signs
        wrc(IDX_SPEED_LIMITS, SUB_FIRST, 32'h0000_0100, 1'b0);
        rdc(IDX_SPEED_LIMITS, SUB_FIRST, 32'h0000_0100);
        wrc(IDX_TARGET_SPEED, SUB_COUNT, 32'h0000_0050, 1'b0);
        wait_clk(10);
        chk({16'h0, demand}, 32'h0000_0100, "clamped to minimum");
        chk({30'h0, word[11:10]}, 32'h0000_0003, "limit and goal bits");
        wrc(IDX_TARGET_SPEED, SUB_COUNT, 32'h0000_FFB0, 1'b0);
        wait_clk(10);
        rdc(IDX_SPEED_DEMAND, SUB_COUNT, 32'hFFFF_FF00);
        // Target above maximum
        wrc(IDX_SPEED_LIMITS, SUB_SECOND, 32'h0000_0200, 1'b0);
        wrc(IDX_TARGET_SPEED, SUB_COUNT, 32'h0000_0300, 1'b0);
        wait_clk(10);
        chk({16'h0, demand}, 32'h0000_0200, "clamped to maximum");
        chk({31'h0, word[11]}, 32'h0000_0001, "limit bit high");
        // Back inside the limits
        wrc(IDX_TARGET_SPEED, SUB_COUNT, 32'h0000_0180, 1'b0);
        wait_clk(10);
        chk({16'h0, demand}, 32'h0000_0180, "inside limits");
        chk({31'h0, word[11]}, 32'h0000_0000, "limit bit cleared");
        // Ramp: 0x10 every 4 cycles, so any 4-cycle span moves one step
        wrc(IDX_ACCEL, SUB_FIRST, 32'h0000_0010, 1'b0);
        wrc(IDX_ACCEL, SUB_SECOND, 32'h0000_0004, 1'b0);
        wrc(IDX_TARGET_SPEED, SUB_COUNT, 32'h0000_01C0, 1'b0);
        wait_clk(2);
        actual = demand;
        wait_clk(4);
        chk({16'h0, demand - actual}, 32'h0000_0010, "ramp step");
        wait_clk(20);
        chk({16'h0, demand}, 32'h0000_01C0, "ramp end");
        test_done;
    end
endmodule
